// [fifo_buffer.sv]
// Synchronous FIFO with valid/ready on both sides.
`default_nettype none
module fifo_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW    = $clog2(DEPTH) + 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData,
    output logic      [CW-1:0]    count
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    wr_d;
    logic [PW-1:0]    rd_q;
    logic [PW-1:0]    rd_d;
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;
    logic             push;
    logic             pop;

    always_comb begin
        inReady  = cnt_q != CW'(DEPTH);
        outValid = cnt_q != '0;
        outData  = mem[rd_q];
        count    = cnt_q;
        push     = inValid && inReady;
        pop      = outReady && outValid;
        wr_d     = push ? PW'(wr_q + 1'b1) : wr_q;
        rd_d     = pop ? PW'(rd_q + 1'b1) : rd_q;
        cnt_d    = CW'(cnt_q + CW'(push) - CW'(pop));
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= inData;
        end
    end
endmodule : fifo_buffer
`default_nettype wire

// [serial_peer.sv]
// Behavioural model of the external serial peer on the shift clock and data lines.
`default_nettype none
module serial_peer (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       sck,
    input  wire logic       edgeSel,
    input  wire logic       lsbFirst,
    input  wire logic [7:0] txByte,
    input  wire logic       load,
    input  wire logic       genClk,
    input  wire logic       sdo,
    output var  logic       sdi,
    output var  logic       peerSck,
    output var  logic [7:0] rxByte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       sckSeen;
    logic       active;
    logic [3:0] bitsSeen;
    logic [4:0] toggles;
    logic [2:0] halfCnt;
    logic [2:0] idx;
    assign idx = lsbFirst ? bitsSeen[2:0] : 3'h7 - bitsSeen[2:0];
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sckSeen <= 1'b1;
            active <= 1'b0;
            bitsSeen <= 4'h0;
            sdi <= 1'b1;
            rxByte <= 8'h00;
            peerSck <= 1'b1;
            toggles <= 5'h00;
            halfCnt <= 3'h0;
        end else begin
            sckSeen <= sck;
            if (load) begin
                active <= 1'b1;
                bitsSeen <= 4'h0;
                sdi <= txByte[lsbFirst ? 0 : 7];
            end else if (active) begin
                if (sck != sckSeen && sck == !edgeSel) begin
                    rxByte <= lsbFirst ? {sdo, rxByte[7:1]} : {rxByte[6:0], sdo};
                    bitsSeen <= bitsSeen + 4'h1;
                    active <= (bitsSeen != 4'h7);
                end else if (sck != sckSeen && bitsSeen != 4'h0) begin
                    sdi <= txByte[idx];
                end
            end else begin
                // Outside a frame the line shows a changing pattern, not a held value.
                sdi <= ~sdi;
            end
            if (genClk) begin
                toggles <= 5'h10;
            end else if (toggles == 5'h00) begin
                peerSck <= !edgeSel;
            end else if (halfCnt == 3'h5) begin
                halfCnt <= 3'h0;
                peerSck <= ~peerSck;
                toggles <= toggles - 5'h01;
            end else begin
                halfCnt <= halfCnt + 3'h1;
            end
        end
    end
endmodule : serial_peer
`default_nettype wire

// [sync_serial_pkg.sv]
// Register map, field positions, reset values and timing counts of the serial port.
`default_nettype none
package sync_serial_pkg;
    localparam logic [7:0] CTRL_ADDR   = 8'hF0;
    localparam logic [7:0] DATA_ADDR   = 8'hF4;
    localparam logic [7:0] STAT_ADDR   = 8'hF8;
    localparam int         CTRL_SRC    = 7;
    localparam int         CTRL_LSB    = 6;
    localparam int         CTRL_TXRX   = 5;
    localparam int         CTRL_EDGE   = 4;
    localparam int         CTRL_START  = 3;
    localparam int         CTRL_EN     = 2;
    localparam int         CTRL_IE     = 1;
    localparam int         CTRL_PEND   = 0;
    localparam logic [7:0] CTRL_RESET  = 8'h80;
    localparam int         STAT_BUSY   = 7;
    localparam int         STAT_FULL   = 6;
    localparam int         STAT_EMPTY  = 5;
    localparam int         DATA_W      = 8;
    localparam int         FIFO_DEPTH  = 16;
    localparam int         HALF_CYC    = 4;
    typedef enum logic {
        IDLE  = 1'b0,
        SHIFT = 1'b1
    } state_e;
endpackage : sync_serial_pkg
`default_nettype wire

// [sync_serial_port.sv]
// Synchronous serial port with APB control, status and receive FIFO.
// How it works
// - Bit 7 picks the shift clock: internal divider or the external pin.
// - Bit 6 picks bit order, MSB first at 0, LSB first at 1.
// - Bit 5 picks receive-only at 0, transmit and receive at 1.
// - Bit 4 at 0: output changes on falling, input sampled on rising edges.
// - Bit 4 at 1: output changes on rising, input sampled on falling edges.
// - Writing 1 to bit 3 clears the 3-bit counter and starts shifting, unless the receive FIFO is full.
// - Bit 2 at 0 freezes the shifter and its counter.
// - Bit 1 lets the pending flag raise the interrupt request.
`default_nettype none
module sync_serial_port
    import sync_serial_pkg::*;
#(
    parameter int HALF = HALF_CYC,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sckIn,
    output logic             sckOut,
    output logic             sckOe,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             irq
);
    localparam int CW = $clog2(DEPTH) + 1;

    state_e      state_q;
    state_e      state_d;
    logic [7:0]  ctrl_q;
    logic [7:0]  ctrl_d;
    logic [7:0]  txData_q;
    logic [7:0]  txData_d;
    logic [7:0]  sh_q;
    logic [7:0]  sh_d;
    logic [2:0]  bitCnt_q;
    logic [2:0]  bitCnt_d;
    logic [7:0]  div_q;
    logic [7:0]  div_d;
    logic        sdo_q;
    logic        sdo_d;
    logic        sckOut_q;
    logic        sckOut_d;
    logic        sckOe_q;
    logic        sckOe_d;
    logic        irq_q;
    logic        irq_d;
    logic        sck1_q;
    logic        sck2_q;
    logic        sdi1_q;
    logic        sdi2_q;
    logic        sckPrev_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic        wrAcc;
    logic        rdAcc;
    logic        setup;
    logic        ctrlWr;
    logic        startW;
    logic        lvl;
    logic        rise;
    logic        fall;
    logic        run;
    logic        rxEdge;
    logic        txEdge;
    logic        done;
    logic        lsb;
    logic        fifoReady;
    logic        fifoValid;
    logic [7:0]  fifoData;
    logic [CW-1:0] fifoCnt;

    fifo_buffer #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_rx_fifo (
        .clk      (ref_clk),
        .reset_n  (reset_n),
        .inValid  (done),
        .inReady  (fifoReady),
        .inData   (sh_d),
        .outValid (fifoValid),
        .outReady (rdAcc && paddr == DATA_ADDR),
        .outData  (fifoData),
        .count    (fifoCnt)
    );

    // Bus decode and shift clock edge detection.
    always_comb begin
        setup  = psel && !penable;
        wrAcc  = psel && penable && pready_q && pwrite;
        rdAcc  = psel && penable && pready_q && !pwrite;
        ctrlWr = wrAcc && paddr == CTRL_ADDR;
        startW = ctrlWr && pwdata[CTRL_START];
        lvl    = ctrl_q[CTRL_SRC] ? sck2_q : sckOut_q;
        rise   = lvl && !sckPrev_q;
        fall   = !lvl && sckPrev_q;
        run    = state_q == SHIFT && ctrl_q[CTRL_EN];
        rxEdge = run && (ctrl_q[CTRL_EDGE] ? fall : rise);
        txEdge = run && (ctrl_q[CTRL_EDGE] ? rise : fall);
        done   = rxEdge && bitCnt_q == 3'h7;
    end

    // Control register; a completion in the same cycle beats a clear.
    always_comb begin
        ctrl_d   = ctrl_q;
        txData_d = txData_q;
        if (ctrlWr) begin
            ctrl_d[7:1] = pwdata[7:1];
            ctrl_d[CTRL_START] = 1'b0;
            if (!pwdata[CTRL_PEND]) begin
                ctrl_d[CTRL_PEND] = 1'b0;
            end
        end
        if (done) begin
            ctrl_d[CTRL_PEND] = 1'b1;
        end
        if (wrAcc && paddr == DATA_ADDR) begin
            txData_d = pwdata[7:0];
        end
        irq_d   = ctrl_d[CTRL_PEND] && ctrl_d[CTRL_IE];
        sckOe_d = !ctrl_d[CTRL_SRC];
    end

    // Shifter, bit counter and output data line.
    always_comb begin
        state_d  = state_q;
        sh_d     = sh_q;
        bitCnt_d = bitCnt_q;
        sdo_d    = sdo_q;
        lsb      = ctrl_d[CTRL_LSB];
        if (rxEdge) begin
            bitCnt_d = 3'(bitCnt_q + 3'h1);
            sh_d = lsb ? {sdi2_q, sh_q[7:1]} : {sh_q[6:0], sdi2_q};
            if (done) begin
                state_d = IDLE;
            end
        end
        if (txEdge) begin
            sdo_d = lsb ? sh_q[0] : sh_q[7];
        end
        // A start is refused while the receive FIFO has no room.
        if (startW && fifoReady) begin
            state_d  = SHIFT;
            bitCnt_d = 3'h0;
            sh_d     = txData_q;
            sdo_d    = lsb ? txData_q[0] : txData_q[7];
        end
        if (!ctrl_d[CTRL_TXRX]) begin
            sdo_d = 1'b1;
        end
    end

    // Internal shift clock: sixteen half periods per byte, idle at the sample level.
    always_comb begin
        div_d    = 8'h00;
        sckOut_d = sckOut_q;
        if (state_q == IDLE) begin
            sckOut_d = !ctrl_q[CTRL_EDGE];
        end else if (ctrl_q[CTRL_EN] && !ctrl_q[CTRL_SRC]) begin
            if (div_q == 8'(HALF - 1)) begin
                sckOut_d = !sckOut_q;
            end else begin
                div_d = 8'(div_q + 8'h01);
            end
        end else begin
            div_d = div_q;
        end
    end

    // APB slave: one wait-free access phase, reads captured in setup.
    always_comb begin
        pready_d  = setup;
        pslverr_d = setup && paddr != CTRL_ADDR && paddr != DATA_ADDR
                    && paddr != STAT_ADDR;
        prdata_d  = 32'h0000_0000;
        if (setup) begin
            unique case (paddr)
                CTRL_ADDR: prdata_d[7:0] = ctrl_q;
                DATA_ADDR: prdata_d[7:0] = fifoValid ? fifoData : 8'h00;
                STAT_ADDR: begin
                    prdata_d[STAT_BUSY]  = state_q == SHIFT;
                    prdata_d[STAT_FULL]  = !fifoReady;
                    prdata_d[STAT_EMPTY] = !fifoValid;
                    prdata_d[4:0]        = 5'(fifoCnt);
                end
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= IDLE;
            ctrl_q    <= CTRL_RESET;
            txData_q  <= 8'h00;
            sh_q      <= 8'h00;
            bitCnt_q  <= 3'h0;
            div_q     <= 8'h00;
            sdo_q     <= 1'b1;
            sckOut_q  <= 1'b1;
            sckOe_q   <= 1'b0;
            irq_q     <= 1'b0;
            sck1_q    <= 1'b1;
            sck2_q    <= 1'b1;
            sdi1_q    <= 1'b1;
            sdi2_q    <= 1'b1;
            sckPrev_q <= 1'b1;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            ctrl_q    <= ctrl_d;
            txData_q  <= txData_d;
            sh_q      <= sh_d;
            bitCnt_q  <= bitCnt_d;
            div_q     <= div_d;
            sdo_q     <= sdo_d;
            sckOut_q  <= sckOut_d;
            sckOe_q   <= sckOe_d;
            irq_q     <= irq_d;
            sck1_q    <= sckIn;
            sck2_q    <= sck1_q;
            sdi1_q    <= sdi;
            sdi2_q    <= sdi1_q;
            sckPrev_q <= lvl;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    always_comb begin
        prdata  = prdata_q;
        pready  = pready_q;
        pslverr = pslverr_q;
        sckOut  = sckOut_q;
        sckOe   = sckOe_q;
        sdo     = sdo_q;
        irq     = irq_q;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    property p_ext_no_drive;
        ctrlWr && pwdata[CTRL_SRC] |=> !sckOe_q;
    endproperty
    a_ext_no_drive: assert property (p_ext_no_drive)
        else $error("shift clock driven with external source selected");

    property p_lsb_first;
        startW && fifoReady && pwdata[CTRL_LSB] && pwdata[CTRL_TXRX]
            |=> sdo_q == $past(txData_q[0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first)
        else $error("first bit out is not the low bit in LSB-first mode");

    property p_rx_only;
        !ctrl_q[CTRL_TXRX] && !ctrlWr |=> sdo_q;
    endproperty
    a_rx_only: assert property (p_rx_only)
        else $error("data line moved in receive-only mode");

    property p_sample_edge;
        state_q == SHIFT && !startW && bitCnt_d != bitCnt_q
            |-> (ctrl_q[CTRL_EDGE] ? fall : rise);
    endproperty
    a_sample_edge: assert property (p_sample_edge)
        else $error("bit counted on the wrong shift clock edge");

    property p_start;
        startW && fifoReady |=> state_q == SHIFT && bitCnt_q == 3'h0
            && !ctrl_q[CTRL_START];
    endproperty
    a_start: assert property (p_start)
        else $error("start did not clear the counter and begin shifting");

    property p_frozen;
        !ctrl_q[CTRL_EN] && !startW |=> $stable(bitCnt_q) && $stable(sh_q);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("shifter moved while disabled");

    property p_irq_mask;
        !ctrl_q[CTRL_IE] && !ctrlWr |=> !irq_q;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt raised while disabled");

    property p_clear;
        ctrlWr && !pwdata[CTRL_PEND] && !done |=> !ctrl_q[CTRL_PEND];
    endproperty
    a_clear: assert property (p_clear)
        else $error("pending flag not cleared by writing zero");

    property p_done;
        done && !startW |=> state_q == IDLE && ctrl_q[CTRL_PEND]
            && (irq_q == ctrl_q[CTRL_IE]);
    endproperty
    a_done: assert property (p_done)
        else $error("eighth bit did not stop the shifter and set pending");

    c_tx_done: cover property (done && ctrl_q[CTRL_TXRX]);
    c_ext_done: cover property (done && ctrl_q[CTRL_SRC]);
    c_fifo_full: cover property (!fifoReady);
    c_irq: cover property ($rose(irq_q));
endmodule : sync_serial_port
`default_nettype wire

// [sync_serial_port_tb.sv]
// Self-checking testbench of the serial port control block.
`default_nettype none
module sync_serial_port_tb;
    import sync_serial_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        load = 1'b0;
    logic        genClk = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [7:0]  cfg = 8'h80;
    logic [7:0]  peerTx = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic [7:0]  rxByte;
    logic        pready, pslverr, sckOut, sckOe, sdi, sdo, irq, peerSck, sck, slvErr;
    int          err_total = 0;
    int          checks_done = 0;
    int          cycles = 0;
    always #25 ref_clk = ~ref_clk;
    assign sck = sckOe ? sckOut : peerSck;
    sync_serial_port dut (.ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sckIn(sck), .sckOut(sckOut), .sckOe(sckOe), .sdi(sdi), .sdo(sdo),
        .irq(irq));
    serial_peer peer (.ref_clk(ref_clk), .reset_n(reset_n), .sck(sck), .edgeSel(cfg[CTRL_EDGE]),
        .lsbFirst(cfg[CTRL_LSB]), .txByte(peerTx), .load(load), .genClk(genClk), .sdo(sdo),
        .sdi(sdi), .peerSck(peerSck), .rxByte(rxByte));
    task automatic summarize();
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            $display("Error at %0t: timeout", $time);
            err_total = err_total + 1;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask : rdChk
    task automatic waitDone();
        rd = 32'h0;
        while (rd[CTRL_PEND] !== 1'b1) begin
            apb(1'b0, CTRL_ADDR, 8'h00);
        end
    endtask : waitDone
    // Configures without the start bit first so that an idle clock level change is not a frame.
    // The peer is armed only once the start has been accepted, so its clock never runs early.
    task automatic xfer(input logic [7:0] c, input logic [7:0] devTx, input logic [7:0] pTx);
        cfg <= c;
        apb(1'b1, CTRL_ADDR, c & 8'hF6);
        apb(1'b1, DATA_ADDR, devTx);
        apb(1'b1, CTRL_ADDR, c);
        peerTx <= pTx;
        load <= 1'b1;
        genClk <= c[CTRL_SRC];
        @(posedge ref_clk);
        load <= 1'b0;
        genClk <= 1'b0;
        if (c[CTRL_EN]) begin
            waitDone();
        end
    endtask : xfer
    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        rdChk(CTRL_ADDR, {24'h0, CTRL_RESET});
        chk({31'h0, sckOe}, 32'h0);
        apb(1'b0, 8'hEC, 8'h00);
        chk({31'h0, slvErr}, 32'h1);
        xfer(8'h2E, 8'hA5, 8'h3C);
        chk({24'h0, rxByte}, 32'hA5);
        chk({31'h0, sckOe}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rdChk(CTRL_ADDR, 32'h27);
        apb(1'b1, CTRL_ADDR, 8'h25);
        rdChk(CTRL_ADDR, 32'h25);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, CTRL_ADDR, 8'h24);
        rdChk(CTRL_ADDR, 32'h24);
        rdChk(DATA_ADDR, 32'h3C);
        xfer(8'h5C, 8'h0F, 8'hC1);
        chk({24'h0, rxByte}, 32'hFF);
        chk({31'h0, irq}, 32'h0);
        rdChk(DATA_ADDR, 32'hC1);
        xfer(8'h7E, 8'h3A, 8'hE4);
        chk({24'h0, rxByte}, 32'h3A);
        chk({31'h0, irq}, 32'h1);
        rdChk(DATA_ADDR, 32'hE4);
        xfer(8'hAC, 8'h96, 8'h5A);
        chk({31'h0, sckOe}, 32'h0);
        chk({24'h0, rxByte}, 32'h96);
        rdChk(DATA_ADDR, 32'h5A);
        xfer(8'h28, 8'h81, 8'h7E);
        repeat (40) @(posedge ref_clk);
        rdChk(STAT_ADDR, 32'hA0);
        apb(1'b1, CTRL_ADDR, 8'h24);
        waitDone();
        chk({24'h0, rxByte}, 32'h81);
        rdChk(DATA_ADDR, 32'h7E);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            xfer(8'h2C, 8'h00, 8'(i));
        end
        rdChk(STAT_ADDR, 32'h50);
        apb(1'b1, CTRL_ADDR, 8'h2C);
        repeat (20) @(posedge ref_clk);
        rdChk(STAT_ADDR, 32'h50);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            rdChk(DATA_ADDR, 32'(i));
        end
        rdChk(STAT_ADDR, 32'h20);
        rdChk(DATA_ADDR, 32'h0);
        summarize();
    end
endmodule : sync_serial_port_tb
`default_nettype wire
